// ### shared/out_sel_pkg.sv
// Constants, types and code decoding shared by the output signal selector
package out_sel_pkg;

  // Terminal count and field widths
  localparam int unsigned TERM_N = 5; // Three transistor and two relay terminals
  localparam int unsigned CODE_W = 11; // Select code width, holds 0 to 1099
  localparam int unsigned FREQ_W = 16; // Frequency word width
  localparam int unsigned STAT_N = 100; // Status signals indexed by base code
  localparam int unsigned IRQ_W = 4; // Interrupt status width

  // Terminal positions in the packed terminal vectors
  localparam int unsigned T_OUT_A = 0; // Transistor output a
  localparam int unsigned T_OUT_B = 1; // Transistor output b
  localparam int unsigned T_OUT_C = 2; // Transistor output c
  localparam int unsigned T_REL_GEN = 3; // General relay
  localparam int unsigned T_REL_ALM = 4; // Alarm relay

  // Register byte offsets on APB
  localparam logic [7:0] OFF_SEL_BASE = 8'h00; // Five select codes, one word each
  localparam logic [7:0] OFF_START_FREQ = 8'h14; // Running indicator on threshold
  localparam logic [7:0] OFF_STOP_FREQ = 8'h18; // Running indicator off threshold
  localparam logic [7:0] OFF_OUT_STATE = 8'h1C; // Read-only terminal state
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20; // Sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24; // Interrupt enables
  localparam logic [5:0] IDX_START = OFF_START_FREQ[7:2]; // Word index forms
  localparam logic [5:0] IDX_STOP = OFF_STOP_FREQ[7:2];
  localparam logic [5:0] IDX_STATE = OFF_OUT_STATE[7:2];
  localparam logic [5:0] IDX_ISTAT = OFF_IRQ_STATUS[7:2];
  localparam logic [5:0] IDX_IMASK = OFF_IRQ_MASK[7:2];

  // Reset values, all in normal polarity
  localparam logic [CODE_W-1:0] DEF_SEL_A = 11'h000; // Running
  localparam logic [CODE_W-1:0] DEF_SEL_B = 11'h001; // Frequency arrival
  localparam logic [CODE_W-1:0] DEF_SEL_C = 11'h002; // Frequency level detected
  localparam logic [CODE_W-1:0] DEF_SEL_GEN = 11'h00A; // Ready to run
  localparam logic [CODE_W-1:0] DEF_SEL_ALM = 11'h063; // Any alarm
  localparam logic [FREQ_W-1:0] DEF_START_FREQ = 16'h0000; // Plain default
  localparam logic [FREQ_W-1:0] DEF_STOP_FREQ = 16'h0000; // Plain default
  localparam logic [IRQ_W-1:0] DEF_IRQ_MASK = 4'h0; // All masked

  // Code arithmetic
  localparam logic [CODE_W-1:0] INV_OFFSET = 11'h3E8; // Inverted code = base + 1000
  localparam logic [CODE_W-1:0] BASE_MAX = 11'h063; // Highest base code, 99
  localparam logic [CODE_W-1:0] SEL_LINE_CONT = 11'h00B; // Line contactor control
  localparam logic [CODE_W-1:0] SEL_DRV_OUT_CONT = 11'h00C; // Drive output contactor
  localparam logic [CODE_W-1:0] SEL_DRV_IN_CONT = 11'h00D; // Drive input contactor

  // Interrupt bit positions
  localparam int unsigned IRQ_REJECT = 0; // Select write refused, value kept
  localparam int unsigned IRQ_UNDEF = 1; // Undefined code stored
  localparam int unsigned IRQ_SETTLED = 2; // Power-on settle interval over
  localparam int unsigned IRQ_ALARM = 3; // Alarm relay went active

  // Settle interval after reset release
  localparam int unsigned SETTLE_TIME_MS = 3000; // About three seconds
  localparam int unsigned CLK_KHZ = 125000; // 125 MHz
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_MS * CLK_KHZ;

  typedef enum logic [0:0] {
    ST_SETTLE = 1'b0, // Outputs not yet trustworthy
    ST_READY = 1'b1 // Settle interval over
  } settle_state_e;

  typedef struct packed {
    logic [FREQ_W-1:0] outFreq; // Present output frequency
    logic dcBraking; // DC braking active
  } run_in_s;

  typedef struct packed {
    logic valid; // Code drives a defined signal
    logic invert; // Active-off polarity
    logic contactorInv; // Inverted contactor code, never accepted
    logic [6:0] idx; // Base code, index into the status vector
  } code_dec_s;

  // Base codes that name a defined status signal
  function automatic logic baseDefined(input logic [6:0] b);
    case (b)
      7'h00, 7'h01, 7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h0A, 7'h0B, 7'h0C, 7'h0D,
      7'h0F, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1E, 7'h21, 7'h23, 7'h24, 7'h25, 7'h2A,
      7'h2B, 7'h2C, 7'h2D, 7'h36, 7'h37, 7'h38, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
      7'h40, 7'h41, 7'h43, 7'h44, 7'h45, 7'h63: baseDefined = 1'b1;
      default: baseDefined = 1'b0;
    endcase
  endfunction : baseDefined

  // Split a select code into signal index and polarity
  function automatic code_dec_s decodeCode(input logic [CODE_W-1:0] code);
    code_dec_s r;
    logic [CODE_W-1:0] b;
    r = '0;
    b = code;
    if (code >= INV_OFFSET) begin
      b = code - INV_OFFSET;
      r.invert = 1'b1;
    end
    if (b <= BASE_MAX) begin
      r.idx = b[6:0];
      r.contactorInv = r.invert && (b >= SEL_LINE_CONT) && (b <= SEL_DRV_IN_CONT);
      r.valid = baseDefined(b[6:0]) && !r.contactorInv;
    end
    return r;
  endfunction : decodeCode

endpackage : out_sel_pkg

// ### verilog/running_indicator.sv
// Running indicator with start and stop frequency hysteresis
`timescale 1ns/1ps
module running_indicator (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire out_sel_pkg::run_in_s runIn, // Output frequency and braking
  input wire logic [out_sel_pkg::FREQ_W-1:0] startFreq, // On threshold
  input wire logic [out_sel_pkg::FREQ_W-1:0] stopFreq, // Off threshold
  output logic running // Registered running flag
);
  import out_sel_pkg::*;

  logic runQ; // Running state
  logic runD; // Next running state

  // Braking wins over both thresholds; between them the flag holds
  assign runD = runIn.dcBraking ? 1'b0 :
                (runIn.outFreq > startFreq) ? 1'b1 :
                (runIn.outFreq < stopFreq) ? 1'b0 : runQ;

  // State flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      runQ <= 1'b0;
    end else begin
      runQ <= runD;
    end
  end

  assign running = runQ;

endmodule : running_indicator

// ### verilog/term_mux.sv
// One terminal's signal selection and polarity
`timescale 1ns/1ps
module term_mux (
  input wire out_sel_pkg::code_dec_s dec, // Decoded select code
  input wire logic [out_sel_pkg::STAT_N-1:0] statusVec, // Status signals by code
  output logic level // Terminal drive level, combinational
);
  import out_sel_pkg::*;

  logic picked; // Selected status signal

  assign picked = statusVec[dec.idx];
  // Undefined codes never drive; inversion flips the asserted sense
  assign level = dec.valid && (picked ^ dec.invert);

endmodule : term_mux

// ### verilog/output_signal_selector.sv
// Output terminal selector: APB registers, muxing, settle timer and interrupt
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Five terminals, each with own select code
// - Code n normal, n plus 1000 inverted
// - Reset settings use normal polarity everywhere
// - Contactor codes 11 to 13 never inverted
// - Alarm relay energizes on alarm, A-C closes
// - Inverted outputs read active when unpowered
// - Code table maps 0 to 99
// - Running on above start, off below stop
// - Switching sequence needs contactors on transistor outputs
module output_signal_selector #(
  parameter int unsigned SETTLE_CYC = out_sel_pkg::SETTLE_CYCLES // Settle length in cycles
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [out_sel_pkg::STAT_N-1:0] driveStatus, // Status signals by code
  input wire out_sel_pkg::run_in_s runIn, // Running indicator inputs
  input wire logic lineSwitchSeqEnableLowfreq, // Sequence requested, low mains
  input wire logic lineSwitchSeqEnableHighfreq, // Sequence requested, high mains
  output logic transistorOutA, // Transistor terminal a, high is ON
  output logic transistorOutB, // Transistor terminal b
  output logic transistorOutC, // Transistor terminal c
  output logic relayOutGeneral, // General relay coil, high energized
  output logic relayOutAlarm, // Alarm relay coil, high energized
  output logic alarmContactAc, // Alarm A-C pair closed
  output logic alarmContactBc, // Alarm B-C pair closed
  output logic integratedSeqActive, // Contactor sequence allowed
  output logic outputsSettled, // Settle interval over
  output logic irq // Level interrupt
);
  import out_sel_pkg::*;

  // Refuse a settle count of 1, which gives a single settle cycle, or 0, which wraps the end compare
  if (SETTLE_CYC < 2) begin : g_bad_settle
    $error("SETTLE_CYC must be at least 2");
  end

  // Register state
  logic [TERM_N-1:0][CODE_W-1:0] selCodeQ; // Select codes, terminal order
  logic [FREQ_W-1:0] startFreqQ; // Running on threshold
  logic [FREQ_W-1:0] stopFreqQ; // Running off threshold
  logic [IRQ_W-1:0] irqStatusQ; // Sticky events
  logic [IRQ_W-1:0] irqMaskQ; // Interrupt enables
  logic irqQ; // Registered interrupt line
  logic [31:0] prdataQ; // Read data, captured in setup
  logic pslverrQ; // Error, captured in setup

  // Terminal and status state
  logic [TERM_N-1:0] termQ; // Registered terminal levels
  logic [TERM_N-1:0] termD; // Next terminal levels
  logic seqActiveQ; // Contactor sequence allowed
  logic seqActiveD; // Next value of the above
  logic runActive; // Running indicator
  logic [STAT_N-1:0] statusVec; // Status vector seen by the muxes
  code_dec_s dec [TERM_N]; // Decoded select codes

  // Settle timer
  settle_state_e stateQ; // Settle state
  settle_state_e stateD; // Next settle state
  logic [31:0] cntQ; // Cycles since reset release
  logic [31:0] cntD; // Next count

  // APB decode
  wire setupPh = psel && !penable; // Setup cycle
  wire accessPh = psel && penable; // Access cycle, always one cycle
  wire [5:0] wordIdx = paddr[7:2]; // Word index
  wire addrMapped = (paddr[1:0] == 2'h0) && (wordIdx <= IDX_IMASK); // Known word
  wire wrEn = accessPh && pwrite && addrMapped; // Write takes effect
  wire selHit = wordIdx < 6'(TERM_N); // Select code word
  wire selWrAny = wrEn && selHit; // Any select code write
  wire [2:0] selIdx = wordIdx[2:0]; // Which terminal is written
  wire startWr = wrEn && (wordIdx == IDX_START); // Start frequency write
  wire stopWr = wrEn && (wordIdx == IDX_STOP); // Stop frequency write
  wire istatWr = wrEn && (wordIdx == IDX_ISTAT); // Status clear write
  wire imaskWr = wrEn && (wordIdx == IDX_IMASK); // Mask write

  // Checks on a select code being written
  wire [CODE_W-1:0] wrCode = pwdata[CODE_W-1:0]; // Candidate code
  wire wrHigh = |pwdata[31:CODE_W]; // Value cannot be a code at all
  code_dec_s wrDec; // Decoded candidate
  assign wrDec = decodeCode(wrCode);
  wire wrAccept = !wrHigh && !wrDec.contactorInv;
  wire evReject = selWrAny && !wrAccept; // Refused write
  wire evUndef = selWrAny && wrAccept && !wrDec.valid; // Stored but inert

  // Select code registers, reset to normal polarity defaults
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      selCodeQ[T_OUT_A] <= DEF_SEL_A;
      selCodeQ[T_OUT_B] <= DEF_SEL_B;
      selCodeQ[T_OUT_C] <= DEF_SEL_C;
      selCodeQ[T_REL_GEN] <= DEF_SEL_GEN;
      selCodeQ[T_REL_ALM] <= DEF_SEL_ALM;
    end else if (selWrAny && wrAccept) begin
      selCodeQ[selIdx] <= wrCode;
    end
  end

  // Frequency thresholds for the running indicator
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      startFreqQ <= DEF_START_FREQ;
      stopFreqQ <= DEF_STOP_FREQ;
    end else begin
      if (startWr) begin
        startFreqQ <= pwdata[FREQ_W-1:0];
      end
      if (stopWr) begin
        stopFreqQ <= pwdata[FREQ_W-1:0];
      end
    end
  end

  // Running indicator replaces status slot zero
  running_indicator u_run (
    .clk_sys(clk_sys),
    .rst(rst),
    .runIn(runIn),
    .startFreq(startFreqQ),
    .stopFreq(stopFreqQ),
    .running(runActive)
  );

  // Integrated switching needs both contactor signals on transistor outputs
  wire lineOnTr = (selCodeQ[T_OUT_A] == SEL_LINE_CONT) || (selCodeQ[T_OUT_B] == SEL_LINE_CONT) ||
                  (selCodeQ[T_OUT_C] == SEL_LINE_CONT);
  wire drvOnTr = (selCodeQ[T_OUT_A] == SEL_DRV_OUT_CONT) ||
                 (selCodeQ[T_OUT_B] == SEL_DRV_OUT_CONT) ||
                 (selCodeQ[T_OUT_C] == SEL_DRV_OUT_CONT);
  wire seqRequest = lineSwitchSeqEnableLowfreq || lineSwitchSeqEnableHighfreq; // Input command
  assign seqActiveD = lineOnTr && drvOnTr && seqRequest;

  // Contactor signals are held off unless the sequence is allowed; a relay
  // carrying one of them would otherwise chatter a contactor it cannot sustain
  assign statusVec = {driveStatus[STAT_N-1:14],
                      driveStatus[13:11] & {3{seqActiveQ}},
                      driveStatus[10:1],
                      runActive};

  // One decoder and mux per terminal
  for (genvar t = 0; t < TERM_N; t++) begin : g_term
    assign dec[t] = decodeCode(selCodeQ[t]);
    term_mux u_mux (
      .dec(dec[t]),
      .statusVec(statusVec),
      .level(termD[t])
    );
  end

  // Terminal flops; reset leaves every coil and transistor off, which is the
  // unpowered state, so inverted terminals read active through reset too
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      termQ <= '0;
      seqActiveQ <= 1'b0;
    end else begin
      termQ <= termD;
      seqActiveQ <= seqActiveD;
    end
  end

  // Settle timer: counts from reset release, then stays ready
  always_comb begin
    stateD = stateQ;
    cntD = cntQ;
    case (stateQ)
      ST_SETTLE: begin
        if (cntQ == 32'(SETTLE_CYC - 1)) begin
          stateD = ST_READY;
        end else begin
          cntD = cntQ + 32'h0000_0001;
        end
      end
      ST_READY: begin
        stateD = ST_READY;
      end
      default: begin
        stateD = ST_SETTLE;
        cntD = 32'h0000_0000;
      end
    endcase
  end

  // Settle state flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateQ <= ST_SETTLE;
      cntQ <= 32'h0000_0000;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
    end
  end

  // Events for the sticky status
  wire evSettled = (stateQ == ST_SETTLE) && (stateD == ST_READY); // Settle ends
  wire evAlarm = termD[T_REL_ALM] && !termQ[T_REL_ALM]; // Alarm coil pulls in
  wire [IRQ_W-1:0] evVec = {evAlarm, evSettled, evUndef, evReject}; // Bit order
  wire [IRQ_W-1:0] clrVec = istatWr ? pwdata[IRQ_W-1:0] : '0; // Write one to clear

  // Sticky status and mask; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatusQ <= '0;
      irqMaskQ <= DEF_IRQ_MASK;
      irqQ <= 1'b0;
    end else begin
      irqStatusQ <= (irqStatusQ & ~clrVec) | evVec;
      if (imaskWr) begin
        irqMaskQ <= pwdata[IRQ_W-1:0];
      end
      irqQ <= |(irqStatusQ & irqMaskQ);
    end
  end

  // Read words; unused bits read as zero
  wire [31:0] selWord = 32'(selCodeQ[selIdx]); // Select code read
  wire [31:0] stateWord = {24'h00_0000, runActive, (stateQ == ST_READY), seqActiveQ, termQ};
  wire [31:0] rdMux = !addrMapped ? 32'h0000_0000 :
                      selHit ? selWord :
                      (wordIdx == IDX_START) ? 32'(startFreqQ) :
                      (wordIdx == IDX_STOP) ? 32'(stopFreqQ) :
                      (wordIdx == IDX_STATE) ? stateWord :
                      (wordIdx == IDX_ISTAT) ? 32'(irqStatusQ) :
                      32'(irqMaskQ);

  // Read data and error are caught in setup so they come from flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdataQ <= 32'h0000_0000;
      pslverrQ <= 1'b0;
    end else if (setupPh) begin
      prdataQ <= pwrite ? 32'h0000_0000 : rdMux;
      pslverrQ <= !addrMapped;
    end
  end

  // Port drive
  assign pready = 1'b1;
  assign prdata = prdataQ;
  assign pslverr = pslverrQ && accessPh;
  assign transistorOutA = termQ[T_OUT_A];
  assign transistorOutB = termQ[T_OUT_B];
  assign transistorOutC = termQ[T_OUT_C];
  assign relayOutGeneral = termQ[T_REL_GEN];
  assign relayOutAlarm = termQ[T_REL_ALM];
  assign alarmContactAc = termQ[T_REL_ALM];
  assign alarmContactBc = !termQ[T_REL_ALM];
  assign integratedSeqActive = seqActiveQ;
  assign outputsSettled = (stateQ == ST_READY);
  assign irq = irqQ;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_normal_follow: assert property (
    (dec[T_REL_ALM].valid && !dec[T_REL_ALM].invert) |=>
      relayOutAlarm == $past(statusVec[dec[T_REL_ALM].idx]))
    else $error("normal terminal does not follow its signal");

  chk_inverted_follow: assert property (
    (dec[T_REL_GEN].valid && dec[T_REL_GEN].invert) |=>
      relayOutGeneral == !$past(statusVec[dec[T_REL_GEN].idx]))
    else $error("inverted terminal does not oppose its signal");

  chk_undef_inactive: assert property (
    !dec[T_OUT_A].valid |=> !transistorOutA)
    else $error("terminal with undefined code is driven");

  chk_reset_defaults: assert property (
    $fell(rst) |-> (!dec[T_OUT_A].invert && !dec[T_OUT_B].invert && !dec[T_OUT_C].invert &&
                    !dec[T_REL_GEN].invert && !dec[T_REL_ALM].invert))
    else $error("inverted polarity present after reset");

  chk_contactor_noinv: assert property (
    (selWrAny && wrDec.contactorInv) |=> $stable(selCodeQ) ##0 irqStatusQ[IRQ_REJECT])
    else $error("inverted contactor code was accepted");

  chk_alarm_contacts: assert property (
    $rose(relayOutAlarm) |-> alarmContactAc && !alarmContactBc)
    else $error("alarm contacts do not match the coil");

  chk_run_on: assert property (
    (runIn.outFreq > startFreqQ && !runIn.dcBraking) |=> runActive)
    else $error("running indicator missed start threshold");

  chk_run_brake: assert property (
    runIn.dcBraking |=> !runActive)
    else $error("running indicator on during braking");

  chk_seq_gate: assert property (
    !integratedSeqActive |-> (statusVec[13:11] == 3'h0))
    else $error("contactor signals pass without the sequence");

  chk_settle_time: assert property (
    $rose(outputsSettled) |-> $past(cntQ) == 32'(SETTLE_CYC - 1))
    else $error("settle interval has the wrong length");

  // A status clear never shares a cycle with a select write, so check every event bit
  chk_set_wins: assert property (
    istatWr |=> ((irqStatusQ & $past(evVec)) == $past(evVec)))
    else $error("event lost against a clear");

  cov_inverted_alarm: cover property (dec[T_REL_ALM].invert && relayOutAlarm);
  cov_reject_write: cover property (evReject);
  cov_settled: cover property ($rose(outputsSettled));
  cov_seq_active: cover property ($rose(integratedSeqActive));

endmodule : output_signal_selector

// ### test/far_side_monitor.sv
// Receiver model: trusts terminals only once settled, counts relay switching
`timescale 1ns/1ps
module far_side_monitor (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [4:0] term, // Terminal levels
  input wire logic settled, // Settle interval over
  output logic [4:0] seenTerm, // Levels the receiver acts on
  output logic [15:0] relayFlips // Relay switching count
);
  logic [4:0] prevQ; // Last sampled terminal levels
  // Levels are masked while the device settles, since they are not trustworthy then
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seenTerm <= 5'h00;
      relayFlips <= 16'h0000;
      prevQ <= 5'h00;
    end else begin
      seenTerm <= settled ? term : 5'h00;
      prevQ <= term;
      // Relays wear out, so their switching is tallied
      if (settled && (prevQ[4:3] != term[4:3])) begin
        relayFlips <= relayFlips + 16'h0001;
      end
    end
  end
endmodule : far_side_monitor

// ### test/output_signal_selector_bench.sv
// Self-checking bench for the output signal selector
`timescale 1ns/1ps
module output_signal_selector_bench;
  import out_sel_pkg::*;
  logic clk_sys = 1'b0; // Clock
  logic rst = 1'b1; // Reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h00000000; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready, pslverr; // APB answer
  logic [STAT_N-1:0] driveStatus = '0; // Status signals
  run_in_s runIn = '0; // Frequency and braking
  logic seqLo = 1'b0, seqHi = 1'b0; // Sequence requests
  logic [4:0] term, seenTerm; // Terminals, receiver view
  logic [15:0] relayFlips; // Relay switching count
  logic acPair, bcPair, seqAct, settled, irq; // Other outputs
  int nFail = 0, checksDone = 0; // Tallies
  logic [6:0] codes [5] = '{7'h01, 7'h02, 7'h03, 7'h0A, 7'h63}; // Codes per terminal
  always #4 clk_sys = ~clk_sys;
  // Short settle so the run stays brief
  output_signal_selector #(.SETTLE_CYC(20)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .driveStatus(driveStatus), .runIn(runIn),
    .lineSwitchSeqEnableLowfreq(seqLo), .lineSwitchSeqEnableHighfreq(seqHi),
    .transistorOutA(term[0]), .transistorOutB(term[1]), .transistorOutC(term[2]),
    .relayOutGeneral(term[3]), .relayOutAlarm(term[4]), .alarmContactAc(acPair),
    .alarmContactBc(bcPair), .integratedSeqActive(seqAct), .outputsSettled(settled), .irq(irq));
  far_side_monitor rx (.clk_sys(clk_sys), .rst(rst), .term(term), .settled(settled),
    .seenTerm(seenTerm), .relayFlips(relayFlips));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // One transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nFail++;
      conclude();
    end
  endtask : apb
  // Write, then let the register and terminal catch up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic setStat(input int c, input logic v);
    @(posedge clk_sys);
    driveStatus[c] <= v;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : setStat
  task automatic setRun(input logic [15:0] f, input logic b);
    @(posedge clk_sys);
    runIn <= '{outFreq: f, dcBraking: b};
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : setRun
  // Defaults after reset: normal polarity, all terminals idle
  task automatic tReset;
    logic [31:0] r;
    logic e;
    logic [CODE_W-1:0] defs [5];
    defs = '{DEF_SEL_A, DEF_SEL_B, DEF_SEL_C, DEF_SEL_GEN, DEF_SEL_ALM};
    check({27'h0, term}, 32'h0);
    check({31'h0, bcPair}, 32'h1);
    for (int t = 0; t < 5; t++) begin
      rd(8'(4 * t), r, e);
      check(r, 32'(defs[t]));
    end
  endtask : tReset
  // Each terminal in both polarities; inverted reads active when the signal is off
  task automatic tPolarity;
    for (int t = 0; t < 5; t++) begin
      wr(8'(4 * t), 32'(codes[t]));
      setStat(codes[t], 1'b1);
      check({31'h0, term[t]}, 32'h1);
      wr(8'(4 * t), 32'(codes[t]) + 32'd1000);
      check({31'h0, term[t]}, 32'h0);
      setStat(codes[t], 1'b0);
      check({31'h0, term[t]}, 32'h1);
    end
    check({30'h0, acPair, bcPair}, 32'h2);
    check({16'h0, relayFlips}, 32'd6);
    check({27'h0, seenTerm}, {27'h0, term});
  endtask : tPolarity
  // Inverted contactor codes refused, raising the reject event
  task automatic tReject;
    logic [31:0] r;
    logic e;
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h5);
    for (int k = 0; k < 3; k++) begin
      wr(8'h20, 32'hF);
      check({31'h0, irq}, 32'h0);
      wr(8'h00, 32'd1011 + 32'(k));
      rd(8'h00, r, e);
      check(r, 32'h5);
      check({31'h0, irq}, 32'h1);
    end
    wr(8'h24, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : tReject
  // Undefined code stored but inert
  task automatic tUndef;
    logic [31:0] r;
    logic e;
    wr(8'h20, 32'hF);
    wr(8'h00, 32'h4);
    setStat(4, 1'b1);
    check({31'h0, term[0]}, 32'h0);
    rd(8'h20, r, e);
    check({31'h0, r[1]}, 32'h1);
    wr(8'h00, 32'd1004);
    check({31'h0, term[0]}, 32'h0);
  endtask : tUndef
  // Running flag with hysteresis and braking override
  task automatic tRun;
    wr(8'h14, 32'd100);
    wr(8'h18, 32'd50);
    wr(8'h00, 32'h0);
    setRun(16'd150, 1'b0);
    check({31'h0, term[0]}, 32'h1);
    setRun(16'd70, 1'b0);
    check({31'h0, term[0]}, 32'h1);
    setRun(16'd40, 1'b0);
    check({31'h0, term[0]}, 32'h0);
    setRun(16'd150, 1'b0);
    setRun(16'd150, 1'b1);
    check({31'h0, term[0]}, 32'h0);
  endtask : tRun
  // Contactor sequence needs codes 11 and 12 on transistor terminals
  task automatic tSeq;
    wr(8'h00, 32'd11);
    wr(8'h04, 32'd12);
    @(posedge clk_sys);
    seqHi <= 1'b1;
    setStat(11, 1'b1);
    check({31'h0, seqAct}, 32'h1);
    check({31'h0, term[0]}, 32'h1);
    wr(8'h04, 32'h1);
    check({31'h0, seqAct}, 32'h0);
    check({31'h0, term[0]}, 32'h0);
    // The low mains request alone must enable the sequence too
    @(posedge clk_sys);
    seqHi <= 1'b0;
    seqLo <= 1'b1;
    wr(8'h04, 32'd12);
    check({31'h0, seqAct}, 32'h1);
  endtask : tSeq
  // Unmapped and unaligned places answer with an error
  task automatic tBus;
    logic [31:0] r;
    logic e;
    rd(8'h28, r, e);
    check({31'h0, e}, 32'h1);
    rd(8'h01, r, e);
    check({31'h0, e}, 32'h1);
    rd(8'h1C, r, e);
    check({31'h0, r[6]}, 32'h1);
    check({31'h0, settled}, 32'h1);
  endtask : tBus
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    tReset();
    tPolarity();
    tReject();
    tUndef();
    tRun();
    tSeq();
    tBus();
    conclude();
  end
endmodule : output_signal_selector_bench
